// ### ebwrs_pkg.sv
// shared constants and types of the external bus wait and read strobe block
package ebwrs_pkg;

  // register byte offsets on the register bus
  localparam logic [4:0] OFF_WAIT_CTRL   = 5'h00;
  localparam logic [4:0] OFF_STROBE_TIME = 5'h04;
  localparam logic [4:0] OFF_ACCESS_CTRL = 5'h08;
  localparam logic [4:0] OFF_STATUS      = 5'h0c;
  localparam logic [4:0] OFF_ACCESS_CNT  = 5'h10;

  // values after reset
  localparam logic [7:0] RST_WAIT_CTRL   = 8'h77;
  localparam logic [7:0] RST_STROBE_TIME = 8'h00;
  localparam logic [7:0] RST_ACCESS_CTRL = 8'hff;

  // writable bits of the wait control byte; bits 7 and 3 stay zero
  localparam logic [7:0] WAIT_CTRL_MASK  = 8'h77;

  // field positions
  localparam int unsigned WAIT_FIELD_W   = 3;
  localparam int unsigned AREA0_WAIT_LSB = 0;
  localparam int unsigned AREA1_WAIT_LSB = 4;
  localparam int unsigned NUM_AREAS      = 8;
  localparam int unsigned AREA_W         = 3;

  // one bus state lasts two mclk cycles, one per half-state
  localparam int unsigned HALF_CYCLES    = 1;

  typedef enum logic [3:0] {
    EB_IDLE = 4'b0001,
    EB_T1   = 4'b0010,
    EB_TW   = 4'b0100,
    EB_T3   = 4'b1000
  } ebwrs_state_t;

endpackage : ebwrs_pkg

// ### ebwrs_cfg_if.sv
// configuration and status carried between register file and bus engine
`timescale 1ns/1ps
`default_nettype none
interface ebwrs_cfg_if;
  import ebwrs_pkg::*;
  logic [2:0]           wait_cnt0;
  logic [2:0]           wait_cnt1;
  logic [7:0]           wait_en;
  logic [7:0]           early_sel;
  logic                 busy;
  ebwrs_state_t         state;
  logic [2:0]           cur_area;
  logic [2:0]           cur_waits;
  logic [15:0]          access_cnt;

  modport regs (output wait_cnt0, wait_cnt1, wait_en, early_sel,
                input  busy, state, cur_area, cur_waits, access_cnt);
  modport engine (input  wait_cnt0, wait_cnt1, wait_en, early_sel,
                  output busy, state, cur_area, cur_waits, access_cnt);
endinterface : ebwrs_cfg_if
`default_nettype wire

// ### ebwrs_regs.sv
// register file of the block as an avalon-mm slave with waitrequest
`timescale 1ns/1ps
`default_nettype none
module ebwrs_regs
  import ebwrs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  ebwrs_cfg_if.regs        cfg
);

  typedef struct packed {
    logic [7:0]  wait_ctrl;
    logic [7:0]  strobe_time;
    logic [7:0]  access_ctrl;
    logic        ack;
    logic [31:0] rdata;
  } ebwrs_reg_state_t;

  ebwrs_reg_state_t st_q;
  ebwrs_reg_state_t st_d;

  // one-hot select; index 5 marks an unmapped address
  function automatic logic [5:0] ebwrs_sel(input logic [4:0] a);
    logic [5:0] s;
    s = 6'h00;
    if (a == OFF_WAIT_CTRL) begin
      s[0] = 1'b1;
    end else if (a == OFF_STROBE_TIME) begin
      s[1] = 1'b1;
    end else if (a == OFF_ACCESS_CTRL) begin
      s[2] = 1'b1;
    end else if (a == OFF_STATUS) begin
      s[3] = 1'b1;
    end else if (a == OFF_ACCESS_CNT) begin
      s[4] = 1'b1;
    end else begin
      s[5] = 1'b1;
    end
    return s;
  endfunction : ebwrs_sel

  logic [5:0] sel;

  always_comb begin
    sel  = ebwrs_sel(avs_address);
    st_d = st_q;
    // every request waits exactly one cycle so read data come from a flop
    st_d.ack = (avs_read | avs_write) & ~st_q.ack;
    if (avs_read & ~st_q.ack) begin
      st_d.rdata = 32'h0000_0000;
      if (sel[0]) begin
        st_d.rdata[7:0] = st_q.wait_ctrl & WAIT_CTRL_MASK; // R4
      end else if (sel[1]) begin
        st_d.rdata[7:0] = st_q.strobe_time; // R5
      end else if (sel[2]) begin
        st_d.rdata[7:0] = st_q.access_ctrl;
      end else if (sel[3]) begin
        st_d.rdata[10:0] = {cfg.cur_waits, cfg.cur_area, cfg.state,
                            cfg.busy};
      end else if (sel[4]) begin
        st_d.rdata[15:0] = cfg.access_cnt;
      end
    end
    if (avs_write & st_q.ack & avs_byteenable[0]) begin
      if (sel[0]) begin
        st_d.wait_ctrl = avs_writedata[7:0] & WAIT_CTRL_MASK; // R4
      end else if (sel[1]) begin
        st_d.strobe_time = avs_writedata[7:0]; // R5
      end else if (sel[2]) begin
        st_d.access_ctrl = avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q.wait_ctrl   <= RST_WAIT_CTRL; // R3
      st_q.strobe_time <= RST_STROBE_TIME; // R10
      st_q.access_ctrl <= RST_ACCESS_CTRL;
      st_q.ack         <= 1'b0;
      st_q.rdata       <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~st_q.ack;
  assign avs_readdata    = st_q.rdata;
  assign cfg.wait_cnt0   = st_q.wait_ctrl[AREA0_WAIT_LSB +: WAIT_FIELD_W];
  assign cfg.wait_cnt1   = st_q.wait_ctrl[AREA1_WAIT_LSB +: WAIT_FIELD_W];
  assign cfg.wait_en     = st_q.access_ctrl;
  assign cfg.early_sel   = st_q.strobe_time;

endmodule : ebwrs_regs
`default_nettype wire

// ### ebwrs_top.sv
// external bus cycle engine with per-area waits and read strobe timing
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] area 1 with waits enabled gets as many wait states as its field
// [R2] area 0 with waits enabled gets as many wait states as its field
// [R3] both wait fields reset to all ones, seven wait states
// [R4] wait control bits 7 and 3 read zero and ignore writes
// [R5] read strobe timing register has one bit per area, bit n for area n
// [R6] bit clear: read strobe released at end of the read cycle
// [R7] bit set: read strobe released one half-state before the end
// [R8] early release also samples read data one half-state earlier
// [R9] strobe timing applies to basic bus interface reads
// [R10] all strobe timing bits reset to zero
// [R11] wait enable clear means the area gets no program waits
module ebwrs_top
  import ebwrs_pkg::*;
#(
  parameter int unsigned ADDR_W = 24,
  parameter int unsigned DATA_W = 16
)
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // register bus
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // access requests from the internal side
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [2:0]        req_area,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   resp_valid,
  output logic [DATA_W-1:0]      resp_rdata,
  // external bus pins
  output logic [ADDR_W-1:0]      ext_addr,
  output logic [7:0]             ext_cs_b,
  output logic                   ext_rd_b,
  output logic                   ext_wr_b,
  output logic [DATA_W-1:0]      ext_data_o,
  output logic                   ext_data_oe,
  input  wire logic [DATA_W-1:0] ext_data_i
);

  typedef struct packed {
    ebwrs_state_t      state;
    logic              half;
    logic [2:0]        wait_left;
    logic [2:0]        wait_used;
    logic              write;
    logic [2:0]        area;
    logic              early;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              resp;
    logic              rd_b;
    logic              wr_b;
    logic [7:0]        cs_b;
    logic              data_oe;
    logic [15:0]       access_cnt;
  } ebwrs_eng_state_t;

  ebwrs_eng_state_t st_q;
  ebwrs_eng_state_t st_d;

  ebwrs_cfg_if cfg ();

  ebwrs_regs u_regs (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .cfg             (cfg)
  );

  // program waits for an area; areas 2 to 7 run without program waits
  function automatic logic [2:0] ebwrs_waits(
    input logic [2:0] area,
    input logic [7:0] en,
    input logic [2:0] cnt0,
    input logic [2:0] cnt1
  );
    logic [2:0] w;
    w = 3'h0;
    if (area == 3'h0 && en[0]) begin
      w = cnt0; // R2
    end else if (area == 3'h1 && en[1]) begin
      w = cnt1; // R1
    end else begin
      w = 3'h0; // R11
    end
    return w;
  endfunction : ebwrs_waits

  // read strobe is low from the second half of T1 on; an early area
  // lets go after the first half of T3, a normal one at the end of T3
  function automatic logic ebwrs_rd_low(
    input ebwrs_state_t s,
    input logic         h,
    input logic         wr,
    input logic         early
  );
    logic low;
    low = 1'b0;
    case (s)
      EB_T1: begin
        low = h;
      end
      EB_TW: begin
        low = 1'b1;
      end
      EB_T3: begin
        low = early ? ~h : 1'b1; // R6 R7
      end
      default: begin
        low = 1'b0;
      end
    endcase
    return low & ~wr;
  endfunction : ebwrs_rd_low

  // write strobe ends half a state before T3 ends so data hold is met
  function automatic logic ebwrs_wr_low(
    input ebwrs_state_t s,
    input logic         h,
    input logic         wr
  );
    logic low;
    low = 1'b0;
    case (s)
      EB_T1: begin
        low = h;
      end
      EB_TW: begin
        low = 1'b1;
      end
      EB_T3: begin
        low = ~h;
      end
      default: begin
        low = 1'b0;
      end
    endcase
    return low & wr;
  endfunction : ebwrs_wr_low

  logic end_of_state;
  logic sample_now;

  always_comb begin
    st_d         = st_q;
    st_d.resp    = 1'b0;
    end_of_state = st_q.half;
    // data are taken at the edge where the strobe is released
    sample_now   = (st_q.state == EB_T3) && !st_q.write &&
                   (st_q.early ? !st_q.half : st_q.half); // R8

    if (st_q.state != EB_IDLE) begin
      st_d.half = ~st_q.half;
    end

    case (st_q.state)
      EB_IDLE: begin
        st_d.half = 1'b0;
        if (req_valid) begin
          st_d.state     = EB_T1;
          st_d.write     = req_write;
          st_d.area      = req_area;
          st_d.addr      = req_addr;
          st_d.wdata     = req_wdata;
          st_d.wait_left = ebwrs_waits(req_area, cfg.wait_en,
                                       cfg.wait_cnt0,
                                       cfg.wait_cnt1); // R1 R2 R11
          st_d.wait_used = st_d.wait_left;
          // every access here is a basic bus interface access
          st_d.early     = cfg.early_sel[req_area] & ~req_write; // R5 R9
        end
      end
      EB_T1: begin
        if (end_of_state) begin
          st_d.state = (st_q.wait_left != 3'h0) ? EB_TW : EB_T3; // R1 R2
        end
      end
      EB_TW: begin
        if (end_of_state) begin
          st_d.wait_left = st_q.wait_left - 3'h1;
          if (st_q.wait_left == 3'h1) begin
            st_d.state = EB_T3;
          end
        end
      end
      EB_T3: begin
        if (end_of_state) begin
          st_d.state      = EB_IDLE;
          st_d.access_cnt = st_q.access_cnt + 16'h0001;
          st_d.resp       = st_q.write;
        end
      end
      default: begin
        st_d.state = EB_IDLE;
        st_d.half  = 1'b0;
      end
    endcase

    if (sample_now) begin
      st_d.rdata = ext_data_i; // R8
      st_d.resp  = 1'b1;
    end

    // pins follow the next state so they change with it, from flops
    st_d.rd_b    = ~ebwrs_rd_low(st_d.state, st_d.half, st_d.write,
                                 st_d.early); // R6 R7
    st_d.wr_b    = ~ebwrs_wr_low(st_d.state, st_d.half, st_d.write);
    st_d.data_oe = st_d.write && (st_d.state != EB_IDLE);
    st_d.cs_b    = 8'hff;
    if (st_d.state != EB_IDLE) begin
      st_d.cs_b[st_d.area] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q.state      <= EB_IDLE;
      st_q.half       <= 1'b0;
      st_q.wait_left  <= 3'h0;
      st_q.wait_used  <= 3'h0;
      st_q.write      <= 1'b0;
      st_q.area       <= 3'h0;
      st_q.early      <= 1'b0;
      st_q.addr       <= '0;
      st_q.wdata      <= '0;
      st_q.rdata      <= '0;
      st_q.resp       <= 1'b0;
      st_q.rd_b       <= 1'b1;
      st_q.wr_b       <= 1'b1;
      st_q.cs_b       <= 8'hff;
      st_q.data_oe    <= 1'b0;
      st_q.access_cnt <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign req_ready      = (st_q.state == EB_IDLE);
  assign resp_valid     = st_q.resp;
  assign resp_rdata     = st_q.rdata;
  assign ext_addr       = st_q.addr;
  assign ext_cs_b       = st_q.cs_b;
  assign ext_rd_b       = st_q.rd_b;
  assign ext_wr_b       = st_q.wr_b;
  assign ext_data_o     = st_q.wdata;
  assign ext_data_oe    = st_q.data_oe;

  assign cfg.busy       = (st_q.state != EB_IDLE);
  assign cfg.state      = st_q.state;
  assign cfg.cur_area   = st_q.area;
  assign cfg.cur_waits  = st_q.wait_used;
  assign cfg.access_cnt = st_q.access_cnt;

endmodule : ebwrs_top
`default_nettype wire

// ### ebwrs_mem_model.sv
// behavioural external memory on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module ebwrs_mem_model (
  input  wire logic        mclk,
  input  wire logic [23:0] ext_addr,
  input  wire logic [7:0]  ext_cs_b,
  input  wire logic        ext_rd_b,
  input  wire logic        ext_wr_b,
  input  wire logic [15:0] ext_data_o,
  input  wire logic        ext_data_oe,
  output logic      [15:0] ext_data_i
);
  logic [15:0] mem [16];
  logic [15:0] last_q;
  // a released bus toggles every cycle so a sample one cycle late never matches
  assign ext_data_i = (!ext_rd_b && ext_cs_b != 8'hff)
                    ? mem[ext_addr[3:0]] : ~last_q;
  always_ff @(posedge mclk) begin
    last_q <= ext_data_i;
    if (!ext_wr_b && ext_data_oe) begin
      mem[ext_addr[3:0]] <= ext_data_o;
    end
  end
endmodule : ebwrs_mem_model
`default_nettype wire

// ### ebwrs_top_asserts.sv
// concurrent checks on the ports of the bus engine
`timescale 1ns/1ps
`default_nettype none
module ebwrs_top_asserts
  import ebwrs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        req_valid,
  input  wire logic        req_ready,
  input  wire logic        req_write,
  input  wire logic [2:0]  req_area,
  input  wire logic        resp_valid,
  input  wire logic [7:0]  ext_cs_b,
  input  wire logic        ext_rd_b,
  input  wire logic        ext_wr_b
);
  logic [7:0] wc_q, st_q, ac_q;
  logic [4:0] lo_q, exp_q;
  logic [2:0] w_d;
  logic       take, wr_ok;
  assign take  = req_valid && req_ready;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_comb begin
    w_d = 3'h0;
    if (req_area == 3'h0 && ac_q[0]) w_d = wc_q[2:0];
    if (req_area == 3'h1 && ac_q[1]) w_d = wc_q[6:4];
  end
  // shadow of the settings so strobe length can be tied to its cause
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wc_q  <= RST_WAIT_CTRL;
      st_q  <= RST_STROBE_TIME;
      ac_q  <= RST_ACCESS_CTRL;
      lo_q  <= 5'h00;
      exp_q <= 5'h00;
    end else begin
      if (wr_ok && avs_address == OFF_WAIT_CTRL) begin
        wc_q <= avs_writedata[7:0] & WAIT_CTRL_MASK;
      end
      if (wr_ok && avs_address == OFF_STROBE_TIME) begin
        st_q <= avs_writedata[7:0];
      end
      if (wr_ok && avs_address == OFF_ACCESS_CTRL) begin
        ac_q <= avs_writedata[7:0];
      end
      lo_q <= ext_rd_b ? 5'h00 : lo_q + 5'h01;
      if (take && !req_write) begin
        exp_q <= 5'h03 + {1'b0, w_d, 1'b0} - {4'h0, st_q[req_area]};
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wait_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer after one wait cycle");
  rd_len_a:
    assert property ($rose(ext_rd_b) |-> lo_q == exp_q)
    else $error("read strobe length wrong");
  early_resp_a: assert property ($rose(ext_rd_b) |-> resp_valid)
    else $error("read data not taken at strobe release");
  cs_area_a: assert property (take |=> ext_cs_b == ~(8'h01 << $past(req_area)))
    else $error("wrong chip select");
  busy_rdy_a: assert property (take |=> !req_ready)
    else $error("ready while busy");
  resp_one_a: assert property (resp_valid |=> !resp_valid)
    else $error("response longer than one cycle");
  rw_excl_a: assert property (!(!ext_rd_b && !ext_wr_b))
    else $error("read and write strobes together");
  wait_rd_a:
    assert property (avs_read && !avs_waitrequest
      && avs_address == OFF_WAIT_CTRL |-> avs_readdata == {24'h0, wc_q})
    else $error("wait control readback");
  strobe_rd_a:
    assert property (avs_read && !avs_waitrequest
      && avs_address == OFF_STROBE_TIME |-> avs_readdata == {24'h0, st_q})
    else $error("strobe timing readback");
  cover property (take && req_write);
  cover property ($rose(ext_rd_b) && exp_q > 5'h08);
  cover property ($rose(ext_rd_b) && exp_q == 5'h02);
endmodule : ebwrs_top_asserts
bind ebwrs_top ebwrs_top_asserts u_chk (.mclk, .rst_b, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .req_valid, .req_ready, .req_write, .req_area, .resp_valid, .ext_cs_b,
  .ext_rd_b, .ext_wr_b);
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the wait and read strobe block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ebwrs_pkg::*;
  logic        mclk, rst_b, avs_read, avs_write, req_valid, req_write;
  logic        req_ready, resp_valid, avs_waitrequest, ext_rd_b, ext_wr_b;
  logic        ext_data_oe;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rnd;
  logic [3:0]  avs_byteenable;
  logic [2:0]  req_area, ar;
  logic [23:0] req_addr, ext_addr;
  logic [15:0] req_wdata, resp_rdata, ext_data_o, ext_data_i, rd;
  logic [7:0]  ext_cs_b, wc, st, ac, v;
  int          fail_count, num_checks, lat, base, ew, i;
  ebwrs_top dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_area(req_area),
    .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .ext_addr(ext_addr), .ext_cs_b(ext_cs_b),
    .ext_rd_b(ext_rd_b), .ext_wr_b(ext_wr_b), .ext_data_o(ext_data_o),
    .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i));
  ebwrs_mem_model u_mem (.mclk(mclk), .ext_addr(ext_addr),
    .ext_cs_b(ext_cs_b), .ext_rd_b(ext_rd_b), .ext_wr_b(ext_wr_b),
    .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
    .ext_data_i(ext_data_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int exp_w(input logic [2:0] a);
    if (a == 3'h0 && ac[0]) return int'(wc[2:0]);
    if (a == 3'h1 && ac[1]) return int'(wc[6:4]);
    return 0;
  endfunction : exp_w
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic av(input logic w, input logic [4:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    @(posedge mclk);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= {24'h0000_00, d};
    n = 0;
    // waitrequest and readdata are seen as they stand at the rising edge
    do begin @(posedge mclk); n++; end while (avs_waitrequest && n < 50);
    if (n >= 50) begin fail_count++; wrap_up(); end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : av
  // latency is counted from the take edge to the response pulse
  task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d);
    int n;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= w;
    req_area  <= a;
    req_addr  <= {20'h0_0000, d[3:0]};
    req_wdata <= d;
    n = 0;
    do begin @(posedge mclk); n++; end while (!req_ready && n < 50);
    req_valid <= 1'b0;
    lat = 0;
    do begin @(negedge mclk); lat++; end while (!resp_valid && lat < 50);
    if (n >= 50 || lat >= 50) begin fail_count++; wrap_up(); end
    rd = resp_rdata;
  endtask : acc
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    {rst_b, avs_read, avs_write, req_valid, req_write} = 5'h00;
    {avs_address, avs_writedata, req_area, req_addr, req_wdata} = '0;
    avs_byteenable = 4'h1;
    rnd = 32'h60e6_750d;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    av(1'b0, OFF_WAIT_CTRL, 8'h00, v); chk(v, 8'h77);
    av(1'b0, OFF_STROBE_TIME, 8'h00, v); chk(v, 8'h00);
    av(1'b1, 5'h14, 8'h5a, v);
    av(1'b0, 5'h14, 8'h00, v); chk(v, 8'h00);
    acc(1'b1, 3'h2, 16'h0000);
    base = lat;
    acc(1'b1, 3'h0, 16'h1234); chk(lat, base + 14);
    acc(1'b0, 3'h1, 16'h1234); chk(lat, base + 14);
    av(1'b0, OFF_ACCESS_CNT, 8'h00, v); chk(v, 8'h03);
    av(1'b0, OFF_STATUS, 8'h00, v); chk(v, 8'h22);
    $display("reset defaults done");
    for (i = 0; i < 24; i++) begin
      rnd = xs(rnd);
      if (i < 2) rnd[23:0] = i ? 24'hff_ffff : 24'hff_ff00;
      ar = (i < 8) ? {2'b00, i[0]} : rnd[26:24];
      wc = rnd[7:0] & WAIT_CTRL_MASK;
      st = rnd[15:8];
      ac = rnd[23:16];
      av(1'b1, OFF_WAIT_CTRL, rnd[7:0], v);
      av(1'b0, OFF_WAIT_CTRL, 8'h00, v); chk(v, wc);
      av(1'b1, OFF_STROBE_TIME, st, v);
      av(1'b0, OFF_STROBE_TIME, 8'h00, v); chk(v, st);
      av(1'b1, OFF_ACCESS_CTRL, ac, v);
      ew = exp_w(ar);
      acc(1'b1, ar, rnd[31:16]); chk(lat, base + 2 * ew);
      acc(1'b0, ar, rnd[31:16]); chk(lat, base + 2 * ew - st[ar]);
      chk(rd, rnd[31:16]);
    end
    $display("random accesses done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
